//--- core/sasc_params.svh
// Offsets, field positions, reset values and counts of the converter control block
`ifndef SASC_PARAMS_SVH
`define SASC_PARAMS_SVH

`define SASC_CTRL_OFS     4'h0
`define SASC_STATUS_OFS   4'h4
`define SASC_RESULT_OFS   4'h8

`define SASC_CTRL_RST     10'h000
`define SASC_CTRL_W       10

`define SASC_RANGE_BIT    0
`define SASC_SEQ_LO_BIT   1
`define SASC_SEQ_HI_BIT   2
`define SASC_MODE_LO_BIT  3
`define SASC_MODE_HI_BIT  4
`define SASC_ADDR_LO_BIT  5
`define SASC_ADDR_HI_BIT  6
`define SASC_CODING_BIT   7
`define SASC_PM_LO_BIT    8
`define SASC_PM_HI_BIT    9

`define SASC_RESULT_RST   12'h000
`define SASC_MSB_TRIAL    12'h800
`define SASC_TWOS_FLIP    12'h800
`define SASC_LAST_BIT_CNT 4'hB
`define SASC_DONE_CNT     4'hC

`define SASC_PM_NORMAL    2'h0
`define SASC_PM_AUTOSHUT  2'h1
`define SASC_PM_AUTOSTBY  2'h2
`define SASC_PM_FULLSHUT  2'h3

`endif

//--- core/sasc_pkg.sv
// Types shared by the converter control block
package sasc_pkg;

  typedef enum logic [0:0] {SAR_IDLE, SAR_CONV} sasc_sar_e;

  typedef struct packed {
    sasc_sar_e   st;
    logic [3:0]  cnt;
    logic [11:0] trial;
    logic [11:0] code;
    logic        done;
  } sasc_sar_s;

  typedef struct packed {
    logic [2:0]  s1;
    logic [2:0]  s2;
    logic [2:0]  s3;
    logic [2:0]  filt;
    logic [9:0]  ctrl;
    logic [1:0]  seq_ptr;
    logic [1:0]  last_ch;
    logic [11:0] result;
    logic        conv;
    logic        start;
    logic        abort;
    logic        step;
    logic        aborted;
    logic        waitreq;
    logic [31:0] rdata;
    logic        track;
    logic [1:0]  pos_sel;
    logic [1:0]  neg_sel;
    logic        neg_gnd;
    logic        span;
    logic        pdown;
    logic        stby;
  } sasc_top_s;

endpackage : sasc_pkg

//--- core/sasc_sar_if.sv
// Link between the sequencer and the approximation engine
`timescale 1ns/1ps
interface sasc_sar_if;
  logic        start;
  logic        abort;
  logic        step;
  logic        comp;
  logic        busy;
  logic        done;
  logic [11:0] trial;
  logic [11:0] code;

  modport ctrl   (output start, output abort, output step, output comp,
                  input busy, input done, input trial, input code);
  modport engine (input start, input abort, input step, input comp,
                  output busy, output done, output trial, output code);
endinterface : sasc_sar_if

//--- core/sasc_sar.sv
// Successive approximation engine timed by conversion clock falling edges
`timescale 1ns/1ps
`include "sasc_params.svh"
module sasc_sar (
  input wire logic  clk,
  input wire logic  reset_n,
  sasc_sar_if.engine sar
);
  sasc_pkg::sasc_sar_s r;
  sasc_pkg::sasc_sar_s n;
  logic [3:0]          idx;

  always_comb begin
    n = r;
    n.done = 1'b0;
    idx = `SASC_LAST_BIT_CNT - r.cnt;
    case (r.st)
      sasc_pkg::SAR_IDLE: begin
        if (sar.start) begin
          n.st = sasc_pkg::SAR_CONV;
          n.cnt = 4'h0;
          n.trial = `SASC_MSB_TRIAL;
        end
      end
      sasc_pkg::SAR_CONV: begin
        // A new trigger cuts the running conversion short and restarts it
        if (sar.start) begin
          n.cnt = 4'h0;
          n.trial = `SASC_MSB_TRIAL;
        end else if (sar.step) begin
          n.cnt = r.cnt + 4'h1;
          if (r.cnt < `SASC_DONE_CNT) begin
            n.trial[idx] = sar.comp;
            if (idx != 4'h0) begin
              n.trial[idx - 4'h1] = 1'b1;
            end
          end else begin
            n.done = 1'b1;
            n.code = r.trial;
            n.st = sasc_pkg::SAR_IDLE;
          end
        end
      end
      default: n.st = sasc_pkg::SAR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{st: sasc_pkg::SAR_IDLE, cnt: 4'h0, trial: 12'h000,
             code: `SASC_RESULT_RST, done: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign sar.busy  = (r.st == sasc_pkg::SAR_CONV);
  assign sar.done  = r.done;
  assign sar.trial = r.trial;
  assign sar.code  = r.code;

  done_after_steps_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.done |-> $past(r.cnt) == `SASC_DONE_CNT && $past(sar.step))
    else $error("conversion finished without thirteen clock periods");

  abort_no_done_a: assert property (@(posedge clk) disable iff (!reset_n)
    sar.abort |=> !r.done ##1 !r.done)
    else $error("aborted conversion still reported a result");

endmodule : sasc_sar

//--- core/sasc_top.sv
// Conversion control, channel sequencer and register slave of the converter
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "sasc_params.svh"
module sasc_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        conversion_trigger,
  input  wire logic        conversion_clock_in,
  input  wire logic        comparator_in,
  output logic             track_enable,
  output logic      [1:0]  vin_pos_sel,
  output logic      [1:0]  vin_neg_sel,
  output logic             neg_to_ground,
  output logic             span_double,
  output logic             power_down,
  output logic             standby_down,
  output logic             busy,
  output logic      [11:0] dac_code
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_diff(input logic [9:0] c);
    return c[`SASC_MODE_HI_BIT:`SASC_MODE_LO_BIT] == 2'h1 ||
           c[`SASC_MODE_HI_BIT:`SASC_MODE_LO_BIT] == 2'h2;
  endfunction : is_diff

  function automatic logic seq_on(input logic [9:0] c);
    // Mixed select codes fall back to the plain per-write mode
    return c[`SASC_SEQ_HI_BIT] & c[`SASC_SEQ_LO_BIT];
  endfunction : seq_on

  function automatic logic [1:0] next_seq(input logic [1:0] p, input logic [9:0] c);
    logic [2:0] nx;
    nx = {1'b0, p} + (is_diff(c) ? 3'h2 : 3'h1);
    if (nx > {1'b0, c[`SASC_ADDR_HI_BIT:`SASC_ADDR_LO_BIT]}) begin
      nx = 3'h0;
    end
    return nx[1:0];
  endfunction : next_seq

  ////////////////////////////////////////////////////////////////////////////
  // State

  sasc_sar_if          sar ();
  sasc_pkg::sasc_top_s r;
  sasc_pkg::sasc_top_s n;
  logic                trig_fall;
  logic                clk_fall;
  logic                bus_write;
  logic [1:0]          ch;
  logic [1:0]          pm;
  logic [31:0]         rd_mux;

  sasc_sar u_sar (
    .clk     (clk),
    .reset_n (reset_n),
    .sar     (sar.engine)
  );

  assign sar.start = r.start;
  assign sar.abort = r.abort;
  assign sar.step  = r.step;
  assign sar.comp  = r.filt[2];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = r;
    ch = 2'h0;
    pm = r.ctrl[`SASC_PM_HI_BIT:`SASC_PM_LO_BIT];
    // Three-stage pin synchronisers; a level counts once stages two and three agree
    n.s1 = {comparator_in, conversion_clock_in, conversion_trigger};
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < 3; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.filt[i] = r.s3[i];
      end
    end
    trig_fall = r.filt[0] & (r.s2[0] == r.s3[0]) & ~r.s3[0];
    clk_fall  = r.filt[1] & (r.s2[1] == r.s3[1]) & ~r.s3[1];
    bus_write = write & ~r.waitreq;

    n.start = trig_fall;
    n.abort = trig_fall & r.conv;
    n.step  = clk_fall;

    if (trig_fall) begin
      ch = seq_on(r.ctrl) ? r.seq_ptr
                          : r.ctrl[`SASC_ADDR_HI_BIT:`SASC_ADDR_LO_BIT];
      n.conv = 1'b1;
      n.last_ch = ch;
      n.pos_sel = ch;
      n.neg_sel = is_diff(r.ctrl) ? (ch ^ 2'h1) : 2'h0;
      n.neg_gnd = ~is_diff(r.ctrl);
      if (seq_on(r.ctrl)) begin
        n.seq_ptr = next_seq(r.seq_ptr, r.ctrl);
      end
    end else if (sar.done) begin
      n.conv = 1'b0;
      n.result = r.ctrl[`SASC_CODING_BIT] ? (sar.code ^ `SASC_TWOS_FLIP)
                                          : sar.code;
    end
    // Sampling switches open for the whole conversion
    n.track = ~n.conv;
    n.span = r.ctrl[`SASC_RANGE_BIT];

    case (pm)
      `SASC_PM_FULLSHUT: begin
        n.pdown = 1'b1;
        n.stby = 1'b0;
      end
      `SASC_PM_AUTOSHUT: begin
        n.stby = 1'b0;
        if (trig_fall) begin
          n.pdown = 1'b0;
        end else if (sar.done) begin
          n.pdown = 1'b1;
        end
      end
      `SASC_PM_AUTOSTBY: begin
        n.pdown = 1'b0;
        if (trig_fall) begin
          n.stby = 1'b0;
        end else if (sar.done) begin
          n.stby = 1'b1;
        end
      end
      default: begin
        n.pdown = 1'b0;
        n.stby = 1'b0;
      end
    endcase

    // Bus slave: one wait cycle, then the access completes
    case (address)
      `SASC_CTRL_OFS:   rd_mux = {22'h0, r.ctrl};
      `SASC_STATUS_OFS: rd_mux = {26'h0, r.last_ch, r.seq_ptr, r.conv, r.aborted};
      `SASC_RESULT_OFS: rd_mux = {18'h0, r.last_ch, r.result};
      default:          rd_mux = 32'h00000000;
    endcase
    if ((read | write) & r.waitreq) begin
      n.waitreq = 1'b0;
      if (read) begin
        n.rdata = rd_mux;
      end
    end else begin
      n.waitreq = 1'b1;
    end
    if (bus_write && address == `SASC_CTRL_OFS) begin
      n.ctrl = writedata[`SASC_CTRL_W-1:0];
      // A control write always restarts the sequence, so a stale pointer
      // left by a late abort is discarded here
      n.seq_ptr = 2'h0;
    end
    if (bus_write && address == `SASC_STATUS_OFS && writedata[0]) begin
      n.aborted = 1'b0;
    end
    if (r.abort) begin
      n.aborted = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{s1: 3'h0, s2: 3'h0, s3: 3'h0, filt: 3'h0, ctrl: `SASC_CTRL_RST,
             seq_ptr: 2'h0, last_ch: 2'h0, result: `SASC_RESULT_RST, conv: 1'b0,
             start: 1'b0, abort: 1'b0, step: 1'b0, aborted: 1'b0, waitreq: 1'b1,
             rdata: 32'h00000000, track: 1'b1, pos_sel: 2'h0, neg_sel: 2'h0,
             neg_gnd: 1'b1, span: 1'b0, pdown: 1'b0, stby: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign readdata      = r.rdata;
  assign waitrequest   = r.waitreq;
  assign track_enable  = r.track;
  assign vin_pos_sel   = r.pos_sel;
  assign vin_neg_sel   = r.neg_sel;
  assign neg_to_ground = r.neg_gnd;
  assign span_double   = r.span;
  assign power_down    = r.pdown;
  assign standby_down  = r.stby;
  assign busy          = r.conv;
  assign dac_code      = sar.trial;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  bus_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
    (read | write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus access not answered after one wait cycle");

  single_channel_a: assert property (@(posedge clk) disable iff (!reset_n)
    trig_fall && !seq_on(r.ctrl) |=>
      vin_pos_sel == $past(r.ctrl[`SASC_ADDR_HI_BIT:`SASC_ADDR_LO_BIT]))
    else $error("single channel mode converted the wrong channel");

  seq_advance_a: assert property (@(posedge clk) disable iff (!reset_n)
    trig_fall && seq_on(r.ctrl) && !bus_write |=>
      r.seq_ptr == next_seq($past(r.seq_ptr), $past(r.ctrl)) && vin_pos_sel == $past(r.seq_ptr))
    else $error("sequencer did not advance on trigger");

  track_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    sar.busy |-> busy && !track_enable)
    else $error("inputs tracked during a conversion");

  neg_ground_a: assert property (@(posedge clk) disable iff (!reset_n)
    trig_fall && !is_diff(r.ctrl) |=> neg_to_ground && vin_neg_sel == 2'h0)
    else $error("single ended input not tied to ground");

  span_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(r.ctrl[`SASC_RANGE_BIT]) |=> span_double)
    else $error("range bit did not double the span");

  full_shut_a: assert property (@(posedge clk) disable iff (!reset_n)
    pm == `SASC_PM_FULLSHUT |=> power_down && !standby_down)
    else $error("full shutdown not applied");

  auto_shut_a: assert property (@(posedge clk) disable iff (!reset_n)
    sar.done && !trig_fall && pm == `SASC_PM_AUTOSHUT |=> power_down)
    else $error("autoshutdown missed after conversion");

  coding_a: assert property (@(posedge clk) disable iff (!reset_n)
    sar.done && !trig_fall && r.ctrl[`SASC_CODING_BIT] |=>
      r.result == ($past(sar.code) ^ `SASC_TWOS_FLIP))
    else $error("twos complement result wrong");

  straight_code_a: assert property (@(posedge clk) disable iff (!reset_n)
    sar.done && !trig_fall && !r.ctrl[`SASC_CODING_BIT] |=> r.result == $past(sar.code))
    else $error("straight binary result wrong");

  seq_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
    trig_fall && seq_on(r.ctrl) &&
      r.seq_ptr == r.ctrl[`SASC_ADDR_HI_BIT:`SASC_ADDR_LO_BIT] |=> r.seq_ptr == 2'h0)
    else $error("sequence did not wrap to channel zero");

  diff_forward_a: assert property (@(posedge clk) disable iff (!reset_n)
    trig_fall && seq_on(r.ctrl) && is_diff(r.ctrl) |=> !vin_pos_sel[0])
    else $error("differential sequence converted an inverse pairing");

  ctrl_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus_write && address == `SASC_CTRL_OFS |=>
      r.seq_ptr == 2'h0 && r.ctrl == $past(writedata[`SASC_CTRL_W-1:0]))
    else $error("control write did not land or restart the sequence");

  read_data_a: assert property (@(posedge clk) disable iff (!reset_n)
    read && waitrequest |=> readdata == $past(rd_mux))
    else $error("read data not loaded for the answer cycle");

  abort_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.abort |=> r.aborted)
    else $error("aborted conversion not flagged");

  status_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus_write && address == `SASC_STATUS_OFS && writedata[0] && !r.abort |=> !r.aborted)
    else $error("abort flag not cleared by status write");

  done_ends_busy_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(busy) |-> $past(sar.done))
    else $error("busy ended without a finished conversion");

  auto_stby_a: assert property (@(posedge clk) disable iff (!reset_n)
    sar.done && !trig_fall && pm == `SASC_PM_AUTOSTBY |=> standby_down && !power_down)
    else $error("autostandby missed after conversion");

  trig_filter_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.start |-> $past(r.filt[0]) && !$past(r.s2[0]) && !$past(r.s3[0]))
    else $error("conversion started without a filtered falling trigger");

  neg_diff_a: assert property (@(posedge clk) disable iff (!reset_n)
    trig_fall && is_diff(r.ctrl) |=> !neg_to_ground && vin_neg_sel == (vin_pos_sel ^ 2'h1))
    else $error("differential pair not selected");

  span_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(r.ctrl[`SASC_RANGE_BIT]) |=> !span_double)
    else $error("range bit did not restore the single span");

endmodule : sasc_top

//--- tb/sasc_far_model.sv
// Far-side model: held analog inputs and the comparator of the converter
`timescale 1ns/1ps
module sasc_far_model #(
  parameter logic [47:0] LEVELS = 48'h0
) (
  input  wire logic        clk,
  input  wire logic [1:0]  vin_pos_sel,
  input  wire logic [11:0] dac_code,
  output logic             comparator_in
);
  initial comparator_in = 1'b0;
  // Keep the trial bit while the trial does not exceed the held input level
  always @(posedge clk) begin
    comparator_in <= (dac_code <= LEVELS[vin_pos_sel*12 +: 12]);
  end
endmodule : sasc_far_model

//--- tb/sasc_top_tb.sv
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
module sasc_top_tb;
  localparam logic [47:0] LEVELS = 48'hABC_789_456_123;
  logic        clk, reset_n, read, write, trig, cclk, comp;
  logic [3:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic        waitrequest, track_enable, neg_to_ground, span_double;
  logic        power_down, standby_down, busy;
  logic [1:0]  vin_pos_sel, vin_neg_sel;
  logic [11:0] dac_code;
  int          n_fail, total_checks;

  sasc_top uut (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .conversion_trigger(trig), .conversion_clock_in(cclk), .comparator_in(comp),
    .track_enable(track_enable), .vin_pos_sel(vin_pos_sel), .vin_neg_sel(vin_neg_sel),
    .neg_to_ground(neg_to_ground), .span_double(span_double), .power_down(power_down),
    .standby_down(standby_down), .busy(busy), .dac_code(dac_code));
  sasc_far_model #(.LEVELS(LEVELS)) far (.clk(clk), .vin_pos_sel(vin_pos_sel),
    .dac_code(dac_code), .comparator_in(comp));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check

  // Request held until waitrequest is sampled low; read data taken at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) n_fail++;
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    // Idle edge so a following call never re-raises a strobe in this step
    @(posedge clk);
  endtask : bus

  // Conversion clock idles low and runs only inside a conversion
  task automatic conv(input int edges, input logic [1:0] ch);
    trig <= 1'b0;
    repeat (8) @(posedge clk);
    check({busy, track_enable, vin_pos_sel}, {2'b10, ch});
    for (int i = 0; i < edges; i++) begin
      cclk <= 1'b1;
      repeat (6) @(posedge clk);
      cclk <= 1'b0;
      repeat (6) @(posedge clk);
      if (i == 11) check(busy, 1'b1);
    end
    trig <= 1'b1;
    repeat (12) @(posedge clk);
    if (edges == 13) check({busy, track_enable}, 2'b01);
  endtask : conv

  task automatic res(input logic [1:0] ch, input logic tw);
    bus(1'b0, 4'h8, 32'h0);
    check(rd, {18'h0, ch, LEVELS[ch*12 +: 12] ^ {tw, 11'h0}});
    check(dac_code, LEVELS[ch*12 +: 12]);
  endtask : res

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    logic [1:0] pe;
    n_fail = 0;
    total_checks = 0;
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    trig = 1'b1;
    cclk = 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    check({waitrequest, track_enable, neg_to_ground, span_double, power_down}, 5'b11100);
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 4'hC, 32'hFFFF);
    bus(1'b0, 4'hC, 32'h0);
    check(rd, 32'h0);
    // Sequencer off: every channel, coding alternating
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 4'h0, (c << 5) | ((c & 1) << 7));
      conv(13, c[1:0]);
      check(neg_to_ground, 1'b1);
      res(c[1:0], c[0]);
    end
    bus(1'b1, 4'h0, 32'h1);
    repeat (2) @(posedge clk);
    check(span_double, 1'b1);
    bus(1'b1, 4'h0, 32'h0);
    repeat (2) @(posedge clk);
    check(span_double, 1'b0);
    // Single-ended sequence up to channel 2, then wrap
    bus(1'b1, 4'h0, 32'h6 | (2 << 5));
    for (int i = 0; i < 4; i++) begin
      conv(13, 2'(i % 3));
      res(2'(i % 3), 1'b0);
    end
    // Fully differential sequence to channel 3: forward pairs only
    bus(1'b1, 4'h0, 32'h16 | (3 << 5));
    for (int i = 0; i < 3; i++) begin
      pe = (i == 1) ? 2'd2 : 2'd0;
      conv(13, pe);
      check({neg_to_ground, vin_neg_sel}, {1'b0, pe ^ 2'd1});
      res(pe, 1'b0);
    end
    // Conversion cut short by a new trigger
    bus(1'b1, 4'h0, 32'h0);
    conv(5, 2'd0);
    conv(13, 2'd0);
    bus(1'b0, 4'h4, 32'h0);
    check(rd[0], 1'b1);
    res(2'd0, 1'b0);
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    check(rd[0], 1'b0);
    // Pseudo differential on channel 3, then mode 11 grounds the negative input
    bus(1'b1, 4'h0, 32'h8 | (3 << 5));
    conv(13, 2'd3);
    check({neg_to_ground, vin_neg_sel}, 3'b010);
    res(2'd3, 1'b0);
    bus(1'b1, 4'h0, 32'h18 | (1 << 5));
    conv(13, 2'd1);
    check({neg_to_ground, vin_neg_sel}, 3'b100);
    res(2'd1, 1'b0);
    // Power modes: normal, autoshutdown, autostandby, full shutdown
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, 4'h0, p << 8);
      conv(13, 2'd0);
      pe = (p == 2) ? 2'b01 : (p == 0) ? 2'b00 : 2'b10;
      check({power_down, standby_down}, pe);
    end
    tally_and_finish();
  end
endmodule : sasc_top_tb
